// ### hdl/vrc_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module vrc_sync import vrc_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic [WIDTH-1:0] din, // Asynchronous input.
    output logic [WIDTH-1:0] dout // Filtered synchronous output.
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_dout = dout;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2[i] == s3[i]) begin
                next_dout[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule : vrc_sync

// ### hdl/vrc_top.sv
// Voltage reference control word with an AXI4-Lite register slave.
`timescale 1ns/1ps
module vrc_top import vrc_pkg::*; (
    input wire logic clk, // 40 MHz system clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable; freezes all state when low.
    input wire logic [VRC_NUM_REQ-1:0] generator_request, // Per module.
    input wire logic [VRC_NUM_REQ-1:0] bandgap_request, // Per module.
    input wire logic [VRC_NUM_REQ-1:0] sampled_mode_request, // Per module.
    input wire logic converter_busy, // Converter busy, asynchronous.
    input wire logic [31:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [31:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic reference_on, // Reference generator enabled.
    output logic bandgap_on, // Bandgap and buffer enabled.
    output logic sampled_mode, // Bandgap runs sampled.
    output logic [1:0] level_select_field, // Effective output level code.
    output logic temp_sensor_on // Temperature sensor enabled.
);
    // =========================================================================
    // Input synchronisation
    // =========================================================================
    // Requests come from analog-side modules, so they are treated as async.
    localparam int SYNC_W = 3 * VRC_NUM_REQ + 1;
    logic [SYNC_W-1:0] sync_out;
    logic [VRC_NUM_REQ-1:0] gen_req;
    logic [VRC_NUM_REQ-1:0] bg_req;
    logic [VRC_NUM_REQ-1:0] mode_req;
    logic busy_in;

    vrc_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .din({converter_busy, sampled_mode_request, bandgap_request,
              generator_request}),
        .dout(sync_out)
    );

    assign gen_req = sync_out[VRC_NUM_REQ-1:0];
    assign bg_req = sync_out[2*VRC_NUM_REQ-1:VRC_NUM_REQ];
    assign mode_req = sync_out[3*VRC_NUM_REQ-1:2*VRC_NUM_REQ];
    assign busy_in = sync_out[SYNC_W-1];

    // =========================================================================
    // Status derivation
    // =========================================================================
    logic [VRC_NUM_REQ-1:0] mode_ok;
    logic any_gen;
    logic any_bg;

    genvar g;
    generate
        for (g = 0; g < VRC_NUM_REQ; g++) begin : g_mode
            // An idle requester's mode line is a don't-care.
            assign mode_ok[g] = mode_req[g] | ~(gen_req[g] | bg_req[g]);
        end
    endgenerate

    assign any_gen = |gen_req;
    assign any_bg = |bg_req;

    // =========================================================================
    // Control and status registers
    // =========================================================================
    logic force_en;
    logic temp_off;
    logic [1:0] level_sel;
    logic gen_busy;
    logic gen_act;
    logic bg_act;
    logic bg_mode;
    logic next_force_en;
    logic next_temp_off;
    logic [1:0] next_level_sel;
    logic next_gen_busy;
    logic next_gen_act;
    logic next_bg_act;
    logic next_bg_mode;
    logic next_reference_on;
    logic next_bandgap_on;
    logic next_sampled_mode;
    logic [1:0] next_level_out;
    logic next_temp_sensor_on;
    logic wr_fire;
    logic [15:0] ctrl_word;

    always_comb begin
        next_force_en = force_en;
        next_temp_off = temp_off;
        next_level_sel = level_sel;
        // Only the low byte holds writable fields; bits 15:8 are ignored.
        if (wr_fire && s_axi_wstrb[0] && !gen_busy) begin
            next_force_en = s_axi_wdata[VRC_FORCE_EN_BIT];
            next_temp_off = s_axi_wdata[VRC_TEMP_OFF_BIT];
            next_level_sel =
                s_axi_wdata[VRC_LEVEL_LO_BIT +: 2];
        end
        next_gen_busy = busy_in;
        next_gen_act = any_gen;
        next_bg_act = any_bg | any_gen | force_en;
        next_bg_mode = (any_gen | any_bg) & (&mode_ok);
        next_reference_on = force_en | any_gen;
        next_bandgap_on = force_en | any_gen | any_bg;
        next_sampled_mode = next_bg_mode;
        next_level_out = level_sel[1] ? VRC_LVL_2V5 :
            (level_sel[0] ? VRC_LVL_2V0 : VRC_LVL_1V5);
        next_temp_sensor_on = ~temp_off;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_en <= 1'b0;
            temp_off <= 1'b0;
            level_sel <= 2'h0;
            gen_busy <= 1'b0;
            gen_act <= 1'b0;
            bg_act <= 1'b0;
            bg_mode <= 1'b0;
            reference_on <= 1'b0;
            bandgap_on <= 1'b0;
            sampled_mode <= 1'b0;
            level_select_field <= VRC_LVL_1V5;
            temp_sensor_on <= 1'b1;
        end else if (ce) begin
            force_en <= next_force_en;
            temp_off <= next_temp_off;
            level_sel <= next_level_sel;
            gen_busy <= next_gen_busy;
            gen_act <= next_gen_act;
            bg_act <= next_bg_act;
            bg_mode <= next_bg_mode;
            reference_on <= next_reference_on;
            bandgap_on <= next_bandgap_on;
            sampled_mode <= next_sampled_mode;
            level_select_field <= next_level_out;
            temp_sensor_on <= next_temp_sensor_on;
        end
    end

    always_comb begin
        ctrl_word = VRC_CTRL_RESET;
        ctrl_word[VRC_MODE_BIT] = bg_mode;
        ctrl_word[VRC_BUSY_BIT] = gen_busy;
        ctrl_word[VRC_BG_ACT_BIT] = bg_act;
        ctrl_word[VRC_GEN_ACT_BIT] = gen_act;
        ctrl_word[VRC_LEVEL_LO_BIT +: 2] = level_sel;
        ctrl_word[VRC_TEMP_OFF_BIT] = temp_off;
        ctrl_word[VRC_FORCE_EN_BIT] = force_en;
    end

    // =========================================================================
    // AXI4-Lite write channel
    // =========================================================================
    // Address and data are taken together in one cycle, which keeps the
    // slave simple at the cost of never accepting one before the other.
    vrc_state_t wr_state;
    vrc_state_t next_wr_state;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;

    assign wr_fire = (wr_state == VRC_ST_IDLE) && s_axi_awvalid &&
        s_axi_wvalid && s_axi_awready && s_axi_wready &&
        (s_axi_awaddr[11:2] == VRC_CTRL_OFFSET[11:2]);

    always_comb begin
        next_wr_state = wr_state;
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        case (wr_state)
            VRC_ST_IDLE: begin
                next_awready = 1'b1;
                next_wready = 1'b1;
                if (s_axi_awvalid && s_axi_wvalid && s_axi_awready &&
                    s_axi_wready) begin
                    next_awready = 1'b0;
                    next_wready = 1'b0;
                    next_bvalid = 1'b1;
                    next_bresp = (s_axi_awaddr[11:2] ==
                        VRC_CTRL_OFFSET[11:2]) ? VRC_RESP_OKAY :
                        VRC_RESP_SLVERR;
                    next_wr_state = VRC_ST_RESP;
                end
            end
            VRC_ST_RESP: begin
                if (s_axi_bready) begin
                    next_bvalid = 1'b0;
                    next_awready = 1'b1;
                    next_wready = 1'b1;
                    next_wr_state = VRC_ST_IDLE;
                end
            end
            default: begin
                next_wr_state = VRC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state <= VRC_ST_IDLE;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= VRC_RESP_OKAY;
        end else if (ce) begin
            wr_state <= next_wr_state;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
        end
    end

    // =========================================================================
    // AXI4-Lite read channel
    // =========================================================================
    vrc_state_t rd_state;
    vrc_state_t next_rd_state;
    logic next_arready;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;

    always_comb begin
        next_rd_state = rd_state;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        case (rd_state)
            VRC_ST_IDLE: begin
                next_arready = 1'b1;
                if (s_axi_arvalid && s_axi_arready) begin
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    if (s_axi_araddr[11:2] == VRC_CTRL_OFFSET[11:2]) begin
                        next_rdata = {16'h0000, ctrl_word};
                        next_rresp = VRC_RESP_OKAY;
                    end else begin
                        next_rdata = 32'h0000_0000;
                        next_rresp = VRC_RESP_SLVERR;
                    end
                    next_rd_state = VRC_ST_RESP;
                end
            end
            VRC_ST_RESP: begin
                if (s_axi_rready) begin
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                    next_rd_state = VRC_ST_IDLE;
                end
            end
            default: begin
                next_rd_state = VRC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state <= VRC_ST_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= VRC_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else if (ce) begin
            rd_state <= next_rd_state;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
endmodule : vrc_top

// ### pkg/vrc_pkg.sv
// Package of constants and types for the voltage reference control block.
package vrc_pkg;
    // =========================================================================
    // Register map
    // =========================================================================
    localparam logic [31:0] VRC_CTRL_OFFSET = 32'h0000_0000;
    localparam logic [15:0] VRC_CTRL_RESET = 16'h0000;
    localparam int VRC_FORCE_EN_BIT = 0;
    localparam int VRC_TEMP_OFF_BIT = 3;
    localparam int VRC_LEVEL_LO_BIT = 4;
    localparam int VRC_GEN_ACT_BIT = 8;
    localparam int VRC_BG_ACT_BIT = 9;
    localparam int VRC_BUSY_BIT = 10;
    localparam int VRC_MODE_BIT = 11;
    localparam int VRC_NUM_REQ = 4;

    // =========================================================================
    // Level codes and AXI responses
    // =========================================================================
    localparam logic [1:0] VRC_LVL_1V5 = 2'h0;
    localparam logic [1:0] VRC_LVL_2V0 = 2'h1;
    localparam logic [1:0] VRC_LVL_2V5 = 2'h2;
    localparam logic [1:0] VRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] VRC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        VRC_ST_IDLE = 2'h0,
        VRC_ST_RESP = 2'h1
    } vrc_state_t;
endpackage : vrc_pkg

// ### verification/test_vrc_top.sv
// Self-checking testbench for the voltage reference control block.
`timescale 1ns/1ps
module test_vrc_top import vrc_pkg::*;;
    logic clk = 0;
    logic rst_n = 0;
    logic ce = 1;
    logic [3:0] gen_req = 0;
    logic [3:0] bg_req = 0;
    logic [3:0] smp_req = 0;
    logic busy = 0;
    logic [31:0] awaddr = 0;
    logic awvalid = 0;
    logic awready;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic wvalid = 0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 0;
    logic [31:0] araddr = 0;
    logic arvalid = 0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 0;
    logic ref_on, bg_on, smp_on, tsens_on;
    logic [1:0] level;
    int n_fail = 0;
    int comparisons = 0;

    vrc_top vrc_top_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .generator_request(gen_req), .bandgap_request(bg_req),
        .sampled_mode_request(smp_req), .converter_busy(busy),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .reference_on(ref_on), .bandgap_on(bg_on),
        .sampled_mode(smp_on), .level_select_field(level),
        .temp_sensor_on(tsens_on));

    // =========================================================================
    // Helpers
    // =========================================================================
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Address and data are offered together and each is released at the
    // edge that takes it; the watchdog is the only limit on any wait.
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do begin
            @(posedge clk);
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    // Read data are accepted one edge after they appear, so the slave
    // must hold its answer through a cycle without rready.
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
            output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        do begin
            @(posedge clk);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task automatic wr(input logic [31:0] d);
        logic [1:0] r;
        axi_write(VRC_CTRL_OFFSET, d, 4'hf, r);
        check(32'(r), 32'(VRC_RESP_OKAY));
    endtask : wr

    task automatic rd_chk(input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(VRC_CTRL_OFFSET, d, r);
        check(d & mask, exp);
        check(32'(r), 32'(VRC_RESP_OKAY));
    endtask : rd_chk

    function automatic logic [31:0] outs();
        return {26'h0, ref_on, bg_on, smp_on, level, tsens_on};
    endfunction : outs

    // The request inputs pass a synchroniser; eight edges cover its delay.
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask : settle

    // =========================================================================
    // Scenarios
    // =========================================================================
    task automatic test_reset;
        rd_chk(32'hffff_ffff, 32'h0);
        check(outs(), 32'h01);
    endtask : test_reset

    task automatic test_all_ones;
        wr(32'hffff_ffff);
        rd_chk(32'hffff_feff, 32'h0239);
        check(outs(), 32'h34);
        check(32'(ref_on), 32'h1);
    endtask : test_all_ones

    task automatic test_levels;
        for (int c = 0; c < 4; c++) begin
            wr(32'(c * 16 + 1));
            rd_chk(32'h0000_0031, 32'(c * 16 + 1));
            check(32'(level), (c == 3) ? 32'h2 : 32'(c));
        end
    endtask : test_levels

    task automatic test_requests;
        wr(32'h0);
        gen_req <= 4'h4;
        smp_req <= 4'hf;
        settle();
        rd_chk(32'hffff_ffff, 32'h0b00);
        check(32'(ref_on), 32'h1);
        smp_req <= 4'hb;
        settle();
        rd_chk(32'hffff_ffff, 32'h0300);
        gen_req <= 4'h0;
        bg_req <= 4'h1;
        smp_req <= 4'hf;
        settle();
        rd_chk(32'hffff_ffff, 32'h0a00);
        check(outs() & 32'h38, 32'h18);
        bg_req <= 4'h0;
        settle();
        rd_chk(32'hffff_ffff, 32'h0);
    endtask : test_requests

    task automatic test_busy;
        wr(32'h10);
        busy <= 1;
        settle();
        rd_chk(32'hffff_ffff, 32'h0410);
        wr(32'h39);
        rd_chk(32'hffff_ffff, 32'h0410);
        check(32'(level), 32'h1);
        busy <= 0;
        settle();
        wr(32'h21);
        rd_chk(32'hffff_feff, 32'h0221);
    endtask : test_busy

    task automatic test_refused;
        logic [31:0] d;
        logic [1:0] r;
        axi_write(32'h4, 32'h1, 4'hf, r);
        check(32'(r), 32'(VRC_RESP_SLVERR));
        axi_read(32'h4, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(VRC_RESP_SLVERR));
        axi_write(VRC_CTRL_OFFSET, 32'h0, 4'h0, r);
        rd_chk(32'hffff_feff, 32'h0221);
    endtask : test_refused

    // With the clock enable low a new request must not reach the outputs.
    task automatic test_freeze;
        wr(32'h0);
        ce <= 1'b0;
        gen_req <= 4'h1;
        settle();
        check(outs(), 32'h01);
        ce <= 1'b1;
        settle();
        check(outs(), 32'h39);
        gen_req <= 4'h0;
        settle();
    endtask : test_freeze

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        test_reset();
        test_all_ones();
        test_levels();
        test_requests();
        test_busy();
        test_refused();
        test_freeze();
        end_sim();
    end

    // A run of a few hundred cycles is expected; this limit is far above it.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end
endmodule : test_vrc_top

// ### verification/vrc_top_asserts.sv
// Concurrent checks on the ports of the voltage reference control block.
`timescale 1ns/1ps
module vrc_top_asserts import vrc_pkg::*; (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic [31:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    input wire logic s_axi_awready, // Write address ready.
    input wire logic s_axi_wvalid, // Write data valid.
    input wire logic s_axi_wready, // Write data ready.
    input wire logic [1:0] s_axi_bresp, // Write response.
    input wire logic s_axi_bvalid, // Write response valid.
    input wire logic [31:0] s_axi_rdata, // Read data.
    input wire logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic reference_on, // Reference enabled.
    input wire logic bandgap_on, // Bandgap enabled.
    input wire logic [1:0] level_select_field, // Level code.
    input wire logic temp_sensor_on // Sensor enabled.
);
    // =========================================================================
    // Checks
    // =========================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_reserved_zero: assert property (
        s_axi_rvalid |-> (s_axi_rdata & 32'hffff_f0c6) == 32'h0000_0000)
        else $error("Reserved read bits not zero.");
    a_reset_state: assert property (
        $rose(rst_n) |-> !reference_on && !bandgap_on &&
            level_select_field == 2'h0 && temp_sensor_on)
        else $error("Outputs not at reset values.");
    a_ref_needs_bg: assert property (
        reference_on |-> bandgap_on)
        else $error("Reference on without bandgap.");
    a_level_code: assert property (
        level_select_field != 2'h3)
        else $error("Level code three driven.");
    a_sampled_active: assert property (
        $rose(s_axi_rvalid) && s_axi_rdata[11] |-> s_axi_rdata[9])
        else $error("Sampled mode with no active requester.");
    a_gen_implies_bg: assert property (
        $rose(s_axi_rvalid) && s_axi_rdata[8] |-> s_axi_rdata[9])
        else $error("Generator active without bandgap active.");
    a_read_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read answer dropped early.");
    a_bad_write: assert property (
        ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
            s_axi_wready && s_axi_awaddr[11:2] != 10'h000 |=>
            s_axi_bvalid && s_axi_bresp == VRC_RESP_SLVERR)
        else $error("Unmapped write not refused.");
endmodule : vrc_top_asserts

bind vrc_top vrc_top_asserts vrc_top_asserts_i (.clk(clk), .rst_n(rst_n),
    .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .reference_on(reference_on), .bandgap_on(bandgap_on),
    .level_select_field(level_select_field),
    .temp_sensor_on(temp_sensor_on));
